// ===== shared/sli_pkg.sv
// Shared constants and types for the status lamp indicator block
package sli_pkg;
    localparam int unsigned CLK_HZ       = 20_000_000;
    localparam int unsigned BLINK_HALF_MS = 500;
    localparam int unsigned BLINK_HALF_CYC = CLK_HZ / 1000 * BLINK_HALF_MS;

    // AXI4-Lite byte offsets
    localparam logic [7:0] REG_LAMP_EN    = 8'h00;
    localparam logic [7:0] REG_LAMP_STATE = 8'h04;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
    localparam logic [7:0] REG_IRQ_ENABLE = 8'h0C;
    localparam logic [7:0] REG_IRQ_CLEAR  = 8'h10;

    // Lamp enable field positions
    localparam int EN_PWR_SLEEP = 0;
    localparam int EN_PWR_AWAKE = 1;
    localparam int EN_EMG       = 2;
    localparam int EN_SIG       = 3;
    localparam int EN_FIX       = 4;
    localparam int EN_MSG       = 5;
    localparam logic [5:0] LAMP_EN_RST = 6'h3F;

    // Interrupt event positions
    localparam int IRQ_SESS_DONE = 0;
    localparam int IRQ_SESS_ERR  = 1;
    localparam int IRQ_EMG_RISE  = 2;
    localparam int IRQ_PWR_CHG   = 3;
    localparam logic [3:0] IRQ_EN_RST = 4'h0;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {FIX_NONE, FIX_2D, FIX_DR, FIX_FULL} sli_fix_t;
    typedef enum logic [1:0] {LAMP_DARK, LAMP_SOLID, LAMP_BLINK} sli_lamp_t;
endpackage

// ===== shared/sli_blink_if.sv
// Blink phase carried from the divider to the lamp logic
interface sli_blink_if;
    logic phase;
    logic wrap;
    modport src (output phase, output wrap);
    modport snk (input  phase, input  wrap);
endinterface

// ===== logic/sli_blink.sv
// Free-running blink divider shared by the signal, position and message lamps
module sli_blink #(
    parameter int unsigned HALF_CYC = 10_000_000
) (
    input  wire logic  i_clk,   // Controller clock
    input  wire logic  i_rst,   // Synchronous reset
    sli_blink_if.src   blk      // Blink phase out
);
    localparam int W = $clog2(HALF_CYC + 1);
    localparam logic [W-1:0] LAST = W'(HALF_CYC - 1);
    logic [W-1:0] cnt;

    if (HALF_CYC < 2) begin : g_bad_half
        $error("sli_blink: HALF_CYC must be at least 2");
    end

    // Equal on and off halves from one counter
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt       <= '0;
            blk.phase <= 1'b0;
            blk.wrap  <= 1'b0;
        end else if (cnt == LAST) begin
            cnt       <= '0;
            blk.phase <= ~blk.phase;
            blk.wrap  <= 1'b1;
        end else begin
            cnt       <= cnt + W'(1);
            blk.wrap  <= 1'b0;
        end
    end

    half_len_a: assert property (@(posedge i_clk) disable iff (i_rst)
        blk.wrap |=> !blk.wrap) else $error("blink wrap longer than one cycle");
endmodule

// ===== logic/sli_top.sv
// Status lamp indicator with AXI4-Lite register access
module sli_top
    import sli_pkg::*;
#(
    parameter int unsigned BLINK_HALF = sli_pkg::BLINK_HALF_CYC
) (
    input  wire logic        I_REF_CLK,       // 20 MHz controller clock
    input  wire logic        I_RST,           // Synchronous reset, active high
    input  wire logic        I_SUPPLY_OK,     // Supply power present
    input  wire logic        I_PWR_BUTTON,    // Power button pin, high pressed
    input  wire logic        I_EMG_BUTTON,    // Emergency button pin, high pressed
    input  wire logic        I_EMERGENCY_INPUT_PIN, // Emergency input pin, high active
    input  wire logic        I_ASLEEP,        // Unit sleeping between reports
    input  wire logic        I_CMD_MODE,      // 1 command mode, 0 tracking mode
    input  wire sli_pkg::sli_fix_t I_FIX_Q,   // Position fix quality
    input  wire logic [2:0]  I_SIG_BARS,      // Signal strength bars 0..5
    input  wire logic        I_SESS_DONE,     // Burst message session finished, pulse
    input  wire logic        I_SESS_ACK,      // Gateway acknowledged transmission
    input  wire logic        I_SESS_RX_ERR,   // Received message had an error
    input  wire logic        I_SESS_FIX_OK,   // Transmission carried a valid fix
    input  wire logic        I_LAST_ERR_NV,   // Stored last-session error at boot
    output logic             O_LAST_ERR,      // Last-session error to store
    output logic             O_LAMP_PWR,      // Power lamp
    output logic             O_LAMP_SIG,      // Satellite signal lamp
    output logic             O_LAMP_FIX,      // Position lamp
    output logic             O_LAMP_MSG,      // Message outcome lamp
    output logic             O_LAMP_EMG,      // Emergency lamp
    output logic             O_IRQ,           // Level interrupt
    input  wire logic [7:0]  S_AXI_AWADDR,    // Write address
    input  wire logic        S_AXI_AWVALID,   // Write address valid
    output logic             S_AXI_AWREADY,   // Write address ready
    input  wire logic [31:0] S_AXI_WDATA,     // Write data
    input  wire logic [3:0]  S_AXI_WSTRB,     // Write strobes
    input  wire logic        S_AXI_WVALID,    // Write data valid
    output logic             S_AXI_WREADY,    // Write data ready
    output logic [1:0]       S_AXI_BRESP,     // Write response
    output logic             S_AXI_BVALID,    // Write response valid
    input  wire logic        S_AXI_BREADY,    // Write response ready
    input  wire logic [7:0]  S_AXI_ARADDR,    // Read address
    input  wire logic        S_AXI_ARVALID,   // Read address valid
    output logic             S_AXI_ARREADY,   // Read address ready
    output logic [31:0]      S_AXI_RDATA,     // Read data
    output logic [1:0]       S_AXI_RRESP,     // Read response
    output logic             S_AXI_RVALID,    // Read data valid
    input  wire logic        S_AXI_RREADY     // Read data ready
);
    import sli_pkg::*;

    if (BLINK_HALF < 2) begin : g_bad_half
        $error("sli_top: BLINK_HALF must be at least 2");
    end

    sli_blink_if blk ();

    sli_blink #(.HALF_CYC(BLINK_HALF)) u_blink (
        .i_clk (I_REF_CLK),
        .i_rst (I_RST),
        .blk   (blk)
    );

    function automatic logic lamp_level(input sli_lamp_t m, input logic ph, input logic en);
        lamp_level = en && ((m == LAMP_SOLID) || ((m == LAMP_BLINK) && ph));
    endfunction

    // Pins: power button, emergency button, emergency input
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic       btn_q;
    logic       emg_q;
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
            btn_q <= 1'b0;
            emg_q <= 1'b0;
        end else begin
            sync1 <= {I_EMERGENCY_INPUT_PIN, I_EMG_BUTTON, I_PWR_BUTTON};
            sync2 <= sync1;
            btn_q <= sync2[0];
            emg_q <= |sync2[2:1];
        end
    end
    wire btn_rise = sync2[0] && !btn_q;
    wire emg_act  = |sync2[2:1];

    // Unit on/off: button toggles, loss of supply turns it off
    logic power_on;
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            power_on <= 1'b0;
        end else if (!I_SUPPLY_OK) begin
            power_on <= 1'b0;
        end else if (btn_rise) begin
            power_on <= !power_on;
        end
    end

    // Registers
    logic [5:0] lamp_en;
    logic [3:0] irq_stat;
    logic [3:0] irq_en;
    logic       aw_held;
    logic       w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    // Session outcome
    wire sess_err = !I_SESS_ACK || I_SESS_RX_ERR;
    wire trk_ok   = I_SESS_ACK && I_SESS_FIX_OK;

    logic      mode_q;
    logic      has_result;
    logic      ever_ok;
    logic      boot_seen;
    logic      boot_err;
    logic      first_done;
    sli_lamp_t msg_mode;
    wire       mode_entry = (I_CMD_MODE != mode_q);

    // Nonvolatile flag is caught one cycle after reset release
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            boot_seen <= 1'b0;
            boot_err  <= 1'b0;
        end else if (!boot_seen) begin
            boot_seen <= 1'b1;
            boot_err  <= I_LAST_ERR_NV;
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            O_LAST_ERR <= 1'b0;
        end else if (!boot_seen) begin
            O_LAST_ERR <= I_LAST_ERR_NV;
        end else if (I_SESS_DONE) begin
            O_LAST_ERR <= sess_err;
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            mode_q     <= 1'b0;
            has_result <= 1'b0;
            ever_ok    <= 1'b0;
            first_done <= 1'b0;
            msg_mode   <= LAMP_DARK;
        end else begin
            mode_q <= I_CMD_MODE;
            if (mode_entry) begin
                has_result <= 1'b0;
                msg_mode   <= LAMP_DARK;
            end else if (I_SESS_DONE) begin
                has_result <= 1'b1;
                first_done <= 1'b1;
                if (I_CMD_MODE) begin
                    if (sess_err) begin
                        msg_mode <= LAMP_DARK;
                    end else if (!first_done && boot_err) begin
                        msg_mode <= LAMP_BLINK;
                    end else begin
                        msg_mode <= LAMP_SOLID;
                    end
                end else begin
                    if (trk_ok) begin
                        ever_ok  <= 1'b1;
                        msg_mode <= LAMP_SOLID;
                    end else if (ever_ok) begin
                        msg_mode <= LAMP_BLINK;
                    end else begin
                        msg_mode <= LAMP_DARK;
                    end
                end
            end
        end
    end

    sli_lamp_t fix_mode;
    sli_lamp_t sig_mode;
    always_comb begin
        case (I_FIX_Q)
            FIX_FULL:        fix_mode = LAMP_SOLID;
            FIX_2D, FIX_DR:  fix_mode = LAMP_BLINK;
            default:         fix_mode = LAMP_DARK;
        endcase
        if (I_SIG_BARS >= 3'h3 && I_SIG_BARS <= 3'h5) begin
            sig_mode = LAMP_SOLID;
        end else if (I_SIG_BARS != 3'h0) begin
            sig_mode = LAMP_BLINK;
        end else begin
            sig_mode = LAMP_DARK;
        end
    end

    // Same lamp logic in both modes; only the message lamp differs
    wire pwr_en = I_ASLEEP ? lamp_en[EN_PWR_SLEEP] : lamp_en[EN_PWR_AWAKE];
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            O_LAMP_PWR <= 1'b0;
            O_LAMP_SIG <= 1'b0;
            O_LAMP_FIX <= 1'b0;
            O_LAMP_MSG <= 1'b0;
            O_LAMP_EMG <= 1'b0;
        end else begin
            O_LAMP_PWR <= pwr_en && power_on && I_SUPPLY_OK;
            O_LAMP_SIG <= lamp_level(sig_mode, blk.phase, lamp_en[EN_SIG]);
            O_LAMP_FIX <= lamp_level(fix_mode, blk.phase, lamp_en[EN_FIX]);
            O_LAMP_MSG <= lamp_level(msg_mode, blk.phase,
                                     lamp_en[EN_MSG] && has_result);
            O_LAMP_EMG <= lamp_en[EN_EMG] && emg_act;
        end
    end

    // AXI4-Lite write path; address and data taken in either order
    wire wr_go = aw_held && w_held && !S_AXI_BVALID;
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= RESP_OKAY;
        end else begin
            S_AXI_AWREADY <= !aw_held && !S_AXI_AWREADY;
            S_AXI_WREADY  <= !w_held && !S_AXI_WREADY;
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_held <= 1'b1;
                aw_addr <= S_AXI_AWADDR;
                S_AXI_AWREADY <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_held <= 1'b1;
                w_data <= S_AXI_WDATA;
                w_strb <= S_AXI_WSTRB;
                S_AXI_WREADY <= 1'b0;
            end
            if (wr_go) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= (aw_addr == REG_LAMP_EN || aw_addr == REG_IRQ_ENABLE ||
                                 aw_addr == REG_IRQ_CLEAR) ? RESP_OKAY : RESP_SLVERR;
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            lamp_en <= LAMP_EN_RST;
            irq_en  <= IRQ_EN_RST;
        end else if (wr_go && w_strb[0]) begin
            if (aw_addr == REG_LAMP_EN) begin
                lamp_en <= w_data[5:0];
            end
            if (aw_addr == REG_IRQ_ENABLE) begin
                irq_en <= w_data[3:0];
            end
        end
    end

    // Sticky events; a new event wins over a clear in the same cycle
    wire [3:0] irq_evt = {btn_rise && I_SUPPLY_OK, emg_act && !emg_q,
                          I_SESS_DONE && sess_err, I_SESS_DONE};
    wire [3:0] irq_clr = (wr_go && w_strb[0] && aw_addr == REG_IRQ_CLEAR) ? w_data[3:0] : 4'h0;
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            irq_stat <= 4'h0;
            O_IRQ    <= 1'b0;
        end else begin
            irq_stat <= (irq_stat & ~irq_clr) | irq_evt;
            O_IRQ    <= |(irq_stat & irq_en);
        end
    end

    // AXI4-Lite read path, one read at a time
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h0000_0000;
            S_AXI_RRESP   <= RESP_OKAY;
        end else if (S_AXI_RVALID) begin
            if (S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b1;
            S_AXI_RRESP   <= RESP_OKAY;
            case (S_AXI_ARADDR)
                REG_LAMP_EN:    S_AXI_RDATA <= {26'h0, lamp_en};
                REG_LAMP_STATE: S_AXI_RDATA <= {22'h0, has_result, power_on, I_CMD_MODE,
                                                O_LAST_ERR, O_LAMP_EMG, O_LAMP_MSG,
                                                O_LAMP_FIX, O_LAMP_SIG, O_LAMP_PWR, 1'b0};
                REG_IRQ_STATUS: S_AXI_RDATA <= {28'h0, irq_stat};
                REG_IRQ_ENABLE: S_AXI_RDATA <= {28'h0, irq_en};
                REG_IRQ_CLEAR:  S_AXI_RDATA <= 32'h0000_0000;
                default: begin
                    S_AXI_RDATA <= 32'h0000_0000;
                    S_AXI_RRESP <= RESP_SLVERR;
                end
            endcase
        end else begin
            S_AXI_ARREADY <= !S_AXI_ARREADY;
        end
    end

    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (I_RST);

    pwr_lamp_a: assert property (O_LAMP_PWR |-> $past(power_on && I_SUPPLY_OK))
        else $error("power lamp lit while unit off");
    fix_dark_a: assert property ((I_FIX_Q == FIX_NONE) |=> !O_LAMP_FIX)
        else $error("position lamp lit without fix");
    fix_solid_a: assert property ((I_FIX_Q == FIX_FULL && lamp_en[EN_FIX]) |=> O_LAMP_FIX)
        else $error("position lamp not solid on full fix");
    sig_level_a: assert property ((I_SIG_BARS inside {3'h3, 3'h4, 3'h5} && lamp_en[EN_SIG])
        |=> O_LAMP_SIG)
        else $error("signal lamp not solid at 3 to 5 bars");
    msg_entry_a: assert property (mode_entry |=> ##1 !O_LAMP_MSG)
        else $error("message lamp lit on mode entry");
    trk_solid_a: assert property ((I_SESS_DONE && !I_CMD_MODE && !mode_entry && trk_ok &&
        lamp_en[EN_MSG]) ##1 (!mode_entry && !I_SESS_DONE) |=> O_LAMP_MSG)
        else $error("tracking message lamp not solid after good session");
    trk_dark_a: assert property (!ever_ok && !I_CMD_MODE |=> ##1 !O_LAMP_MSG || ever_ok)
        else $error("tracking message lamp lit before any delivered fix");
    emg_lamp_a: assert property ((emg_act && lamp_en[EN_EMG]) |=> O_LAMP_EMG)
        else $error("emergency lamp dark while emergency active");
    cmd_blink_a: assert property ((msg_mode == LAMP_BLINK && I_CMD_MODE && mode_q) |-> boot_err)
        else $error("command blink without errored boot session");
    lamp_off_a: assert property ((!lamp_en[EN_SIG] && !lamp_en[EN_FIX] && !lamp_en[EN_MSG])
        |=> !O_LAMP_SIG && !O_LAMP_FIX && !O_LAMP_MSG)
        else $error("disabled lamp lit");
    en_reset_a: assert property (@(posedge I_REF_CLK) disable iff (1'b0)
        I_RST |=> lamp_en == LAMP_EN_RST)
        else $error("lamp enables not all on after reset");
    bresp_hold_a: assert property ((S_AXI_BVALID && !S_AXI_BREADY)
        |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write response dropped before ready");

    blink_msg_c: cover property (I_CMD_MODE && msg_mode == LAMP_BLINK ##1 O_LAMP_MSG);
    trk_blink_c: cover property (!I_CMD_MODE && msg_mode == LAMP_BLINK);
    emg_irq_c:   cover property (irq_stat[IRQ_EMG_RISE] && irq_en[IRQ_EMG_RISE] ##1 O_IRQ);
    pwr_on_c:    cover property (btn_rise ##[1:3] O_LAMP_PWR);
endmodule

// ===== tb/sli_lamp_panel.sv
// Front-panel lamp model seen by the bench
module sli_lamp_panel (
    input  wire logic [4:0] i_lamps, // Lamp drives {emg,msg,fix,sig,pwr}
    output logic      [4:0] o_lit    // Lamps seen lit
);
    timeunit 1ns;
    timeprecision 1ns;
    // Passive lamps: no state, so a missed update shows at once
    assign o_lit = i_lamps;
endmodule

// ===== tb/tb_status_led_indicator.sv
// Self-checking bench for the status lamp block
module tb_status_led_indicator;
    timeunit 1ns;
    timeprecision 1ns;
    import sli_pkg::*;
    localparam int BH = 8;
    localparam int NW = 2 * BH + 4;
    typedef struct {string nm; int sel; logic [31:0] ex;} sli_note_t;
    logic clk = 0, rst = 1, sup = 0, pbtn = 0, ebtn = 0, epin = 0, slp = 0, cmd = 0;
    logic sd = 0, sack = 0, srx = 0, sfix = 0, nv = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    logic [2:0] bars = 0;
    logic [7:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rdat, bdat, r;
    logic [1:0] brsp, rrsp, bres;
    logic lp, ls, lf, lm, le, lerr, irq, awr, wrd, bv, arr, rv, mbusy = 0;
    logic [4:0] lit;
    sli_fix_t fq = FIX_NONE;
    sli_note_t q[$];
    int fail_count = 0, total_checks = 0;
    int ebit[5] = '{1, 3, 4, 5, 2};
    event go;

    initial forever #25 clk = ~clk;

    sli_top #(.BLINK_HALF(BH)) dut (
        .I_REF_CLK(clk), .I_RST(rst), .I_SUPPLY_OK(sup), .I_PWR_BUTTON(pbtn),
        .I_EMG_BUTTON(ebtn), .I_EMERGENCY_INPUT_PIN(epin), .I_ASLEEP(slp), .I_CMD_MODE(cmd),
        .I_FIX_Q(fq), .I_SIG_BARS(bars), .I_SESS_DONE(sd), .I_SESS_ACK(sack),
        .I_SESS_RX_ERR(srx), .I_SESS_FIX_OK(sfix), .I_LAST_ERR_NV(nv), .O_LAST_ERR(lerr),
        .O_LAMP_PWR(lp), .O_LAMP_SIG(ls), .O_LAMP_FIX(lf), .O_LAMP_MSG(lm), .O_LAMP_EMG(le),
        .O_IRQ(irq), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
        .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd),
        .S_AXI_BRESP(brsp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(ara),
        .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rrsp),
        .S_AXI_RVALID(rv), .S_AXI_RREADY(rr));
    sli_lamp_panel panel (.i_lamps({le, lm, lf, ls, lp}), .o_lit(lit));

    task final_report;
        if (fail_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task tmo;
        fail_count++;
        final_report();
    endtask

    task cy(input int n);
        repeat (n) @(posedge clk);
    endtask

    task chk(input string nm, input int sel, input logic [31:0] ex);
        q.push_back('{nm, sel, ex});
        mbusy = 1;
        -> go;
        wait (mbusy == 0);
        @(posedge clk);
    endtask

    // Lamp modes are judged over one blink period plus four cycles so one phase cannot fool it
    initial begin
        sli_note_t n;
        logic [31:0] s;
        logic u;
        int c;
        forever begin
            @(go);
            n = q.pop_front();
            // Mode and session changes reach the lamps two edges late
            repeat (3) @(negedge clk);
            s = (n.sel == 5) ? bdat : (n.sel == 6) ? bres : (n.sel == 7) ? irq : lerr;
            if (n.sel < 5) begin
                c = 0;
                u = 0;
                for (int k = 0; k < NW; k++) begin
                    @(negedge clk);
                    u |= $isunknown(lit[n.sel]);
                    c += (lit[n.sel] === 1'b1);
                end
                s = (c == 0) ? LAMP_DARK : (c == NW) ? LAMP_SOLID : LAMP_BLINK;
                if (u)
                    s = 'x;
            end
            total_checks++;
            if (s !== n.ex) begin
                fail_count++;
                $display("MISMATCH %s expected %0h seen %0h", n.nm, n.ex, s);
            end
            mbusy = 0;
        end
    end

    task axw(input logic [7:0] a, input logic [31:0] d);
        int t;
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1;
        wv <= 1;
        br <= 1;
        for (t = 0; t < 40; t++) begin
            @(posedge clk);
            if (awv && awr)
                awv <= 0;
            if (wv && wrd)
                wv <= 0;
            if (bv)
                break;
        end
        br <= 0;
        bres = brsp;
        if (t == 40)
            tmo();
    endtask

    task axr(input logic [7:0] a);
        int t;
        @(posedge clk);
        ara <= a;
        arv <= 1;
        rr <= 1;
        for (t = 0; t < 40; t++) begin
            @(posedge clk);
            if (arv && arr)
                arv <= 0;
            if (rv)
                break;
        end
        rr <= 0;
        bdat = rdat;
        bres = rrsp;
        if (t == 40)
            tmo();
    endtask

    task rs(input logic v);
        rst <= 1;
        nv <= v;
        cy(3);
        rst <= 0;
        cy(2);
    endtask

    task ses(input logic a, input logic x, input logic f);
        @(posedge clk);
        sd <= 1;
        sack <= a;
        srx <= x;
        sfix <= f;
        @(posedge clk);
        sd <= 0;
        cy(3);
    endtask

    task prs;
        pbtn <= 1;
        cy(5);
        pbtn <= 0;
        cy(5);
    endtask

    initial begin
        #2000000;
        tmo();
    end

    initial begin
        void'($urandom(32'hD3A12218));
        rs(1'b0);
        axr(REG_LAMP_EN);
        chk("lamp_en", 5, 32'h0000003F);
        axr(8'h14);
        chk("bad_rd", 6, RESP_SLVERR);
        axw(REG_LAMP_STATE, 32'h0);
        chk("ro_wr", 6, RESP_SLVERR);
        chk("msg_init", 3, LAMP_DARK);
        sup <= 1;
        prs();
        chk("pwr_on", 0, LAMP_SOLID);
        sup <= 0;
        cy(2);
        chk("pwr_nosup", 0, LAMP_DARK);
        sup <= 1;
        prs();
        for (int b = 0; b < 6; b++) begin
            bars <= b[2:0];
            chk("sig", 1, b == 0 ? LAMP_DARK : b < 3 ? LAMP_BLINK : LAMP_SOLID);
        end
        for (int f = 0; f < 4; f++) begin
            fq <= sli_fix_t'(f[1:0]);
            chk("fix", 2, f == 3 ? LAMP_SOLID : f == 0 ? LAMP_DARK : LAMP_BLINK);
        end
        for (int e = 0; e < 2; e++) begin
            ebtn <= (e == 0);
            epin <= (e == 1);
            cy(5);
            chk("emg_on", 4, LAMP_SOLID);
            ebtn <= 0;
            epin <= 0;
            cy(5);
            chk("emg_off", 4, LAMP_DARK);
        end
        axw(REG_IRQ_ENABLE, 32'h3);
        ses(1'b0, 1'b0, 1'($urandom % 2));
        chk("msg_none", 3, LAMP_DARK);
        chk("err_flag", 8, 1);
        chk("irq_set", 7, 1);
        axw(REG_IRQ_CLEAR, 32'h3);
        cy(2);
        chk("irq_clr", 7, 0);
        ses(1'b1, 1'b0, 1'b1);
        chk("msg_ok", 3, LAMP_SOLID);
        ses(1'b1, 1'b0, 1'b0);
        chk("msg_nofix", 3, LAMP_BLINK);
        cmd <= 1;
        chk("msg_cmd", 3, LAMP_DARK);
        chk("fix_cmd", 2, LAMP_SOLID);
        ses(1'b0, 1'b0, 1'b1);
        chk("cmd_noack", 3, LAMP_DARK);
        ses(1'b1, 1'b1, 1'b1);
        chk("cmd_rxerr", 3, LAMP_DARK);
        ses(1'b1, 1'b0, 1'b0);
        chk("cmd_ok", 3, LAMP_SOLID);
        ebtn <= 1;
        r = $urandom & 32'h3F;
        axw(REG_LAMP_EN, r);
        for (int k = 0; k < 5; k++)
            chk("masked", k, r[ebit[k]] ? LAMP_SOLID : LAMP_DARK);
        axw(REG_LAMP_EN, 32'h07);
        chk("sig_off", 1, LAMP_DARK);
        axw(REG_LAMP_EN, 32'h3E);
        slp <= 1;
        chk("pwr_sleep", 0, LAMP_DARK);
        slp <= 0;
        chk("pwr_awake", 0, LAMP_SOLID);
        ebtn <= 0;
        rs(1'b1);
        chk("boot_err", 8, 1);
        chk("msg_boot", 3, LAMP_DARK);
        ses(1'b1, 1'b0, 1'b1);
        chk("cmd_recover", 3, LAMP_BLINK);
        ses(1'b1, 1'b0, 1'b1);
        chk("cmd_again", 3, LAMP_SOLID);
        final_report();
    end
endmodule
